//--- hdl/ttp_pkg.sv
// constants and carrier types of the triple timer with prescaler
package ttp_pkg;
    localparam int unsigned CNT_W = 8;
    localparam int unsigned ADDR_W = 5;

    // register byte offsets
    localparam logic [4:0] OFF_PRESCALER_ONE = 5'h00;
    localparam logic [4:0] OFF_TIMER_ONE     = 5'h04;
    localparam logic [4:0] OFF_T2_PRIMARY    = 5'h08;
    localparam logic [4:0] OFF_T2_SECONDARY  = 5'h0c;
    localparam logic [4:0] OFF_TIMER_THREE   = 5'h10;
    localparam logic [4:0] OFF_CONTROL       = 5'h14;
    localparam logic [4:0] OFF_IRQ_REQUEST   = 5'h18;

    // control register field positions
    localparam int unsigned CTRL_T1_STOP_BIT = 0;
    localparam int unsigned CTRL_T2_STOP_BIT = 1;
    localparam int unsigned CTRL_T3_STOP_BIT = 2;
    localparam int unsigned CTRL_T2_SRC_BIT  = 3;
    localparam int unsigned CTRL_T3_SRC_BIT  = 4;
    localparam int unsigned CTRL_W           = 5;

    // request register field positions
    localparam int unsigned IRQ_T1_BIT = 0;
    localparam int unsigned IRQ_T2_BIT = 1;
    localparam int unsigned IRQ_T3_BIT = 2;
    localparam int unsigned IRQ_W      = 3;

    // reset values
    localparam logic [7:0] RST_COUNT   = 8'hff;
    localparam logic [4:0] RST_CONTROL = 5'h00;
    localparam logic [2:0] RST_IRQ     = 3'h0;

    // oscillator divider feeding the prescaler
    localparam int unsigned OSC_DIV   = 16;
    localparam int unsigned OSC_DIV_W = 4;
    localparam logic [3:0]  OSC_LAST  = 4'(OSC_DIV - 1);

    typedef struct packed {
        logic t3_src;
        logic t2_src;
        logic t3_stop;
        logic t2_stop;
        logic t1_stop;
    } ttp_ctrl_s;

    typedef struct packed {
        logic t3;
        logic t2;
        logic t1;
    } ttp_irq_s;

    typedef enum logic {PHASE_PRIMARY, PHASE_SECONDARY} ttp_phase_e;
endpackage : ttp_pkg

//--- hdl/ttp_osc_div.sv
// divide-by-sixteen enable generator for the prescaler
`timescale 1ns/1ps
`default_nettype none
module ttp_osc_div (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    output logic      tick
);
    logic [ttp_pkg::OSC_DIV_W-1:0] div_reg;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 4'h1;
        end
    end

    assign tick = (div_reg == ttp_pkg::OSC_LAST);
endmodule : ttp_osc_div
`default_nettype wire

//--- hdl/ttp_reload_counter.sv
// 8-bit down counter with reload on underflow and direct load
`timescale 1ns/1ps
`default_nettype none
module ttp_reload_counter (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       count_en,
    input  wire logic       load_en,
    input  wire logic [7:0] load_value,
    input  wire logic [7:0] reload_value,
    output logic      [7:0] count_reg,
    output logic            underflow
);
    // a software load in the same cycle wins and swallows the underflow
    assign underflow = count_en && !load_en && (count_reg == 8'h00);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= ttp_pkg::RST_COUNT;
        end else if (load_en) begin
            count_reg <= load_value;
        end else if (underflow) begin
            count_reg <= reload_value;
        end else if (count_en) begin
            count_reg <= count_reg - 8'h01;
        end
    end
endmodule : ttp_reload_counter
`default_nettype wire

//--- hdl/ttp_timers.sv
// three reload timers with prescaler behind an avalon-mm slave
`timescale 1ns/1ps
`default_nettype none
module ttp_timers (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic      [2:0]  irq_request,
    output logic             t2_underflow_pulse,
    output logic             t3_underflow_pulse
);
    ////////////////////////////////////////////////////////////////////////////
    // bus slave
    logic                ack_reg;
    logic                wr_go;
    logic                rd_capture;
    logic [7:0]          wdata;
    logic [31:0]         rdata_next;
    ttp_pkg::ttp_ctrl_s  ctrl_reg;
    ttp_pkg::ttp_irq_s   irq_reg;
    ttp_pkg::ttp_irq_s   irq_next;
    ttp_pkg::ttp_phase_e phase_reg;
    logic [7:0]          pre_latch_reg;
    logic [7:0]          t1_latch_reg;
    logic [7:0]          t2_pri_latch_reg;
    logic [7:0]          t2_sec_latch_reg;
    logic [7:0]          t3_latch_reg;
    logic [7:0]          pre_count;
    logic [7:0]          t1_count;
    logic [7:0]          t2_count;
    logic [7:0]          t3_count;
    logic                pre_uf;
    logic                t1_uf;
    logic                t2_uf;
    logic                t3_uf;
    logic                osc_tick;
    logic                t2_en;
    logic                t3_en;
    logic                pre_load;
    logic                t1_load;
    logic                t2_load;
    logic                t3_load;
    logic [7:0]          t2_reload;

    // one wait state: read data is captured in the first cycle
    assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
    assign wr_go           = avs_write && ack_reg;
    assign rd_capture      = avs_read && !ack_reg;
    assign wdata           = avs_writedata[7:0];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avs_read || avs_write) && !ack_reg;
        end
    end

    always_comb begin
        rdata_next = 32'h0000_0000;
        unique case (avs_address)
            ttp_pkg::OFF_PRESCALER_ONE: rdata_next[7:0] = pre_count;
            ttp_pkg::OFF_TIMER_ONE:     rdata_next[7:0] = t1_count;
            ttp_pkg::OFF_T2_PRIMARY:    rdata_next[7:0] = t2_count;
            ttp_pkg::OFF_T2_SECONDARY:  rdata_next[7:0] = t2_sec_latch_reg;
            ttp_pkg::OFF_TIMER_THREE:   rdata_next[7:0] = t3_count;
            ttp_pkg::OFF_CONTROL:       rdata_next[4:0] = ctrl_reg;
            ttp_pkg::OFF_IRQ_REQUEST:   rdata_next[2:0] = irq_reg;
            default:                    rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_capture) begin
            avs_readdata <= rdata_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= ttp_pkg::RST_CONTROL;
        end else if (wr_go && avs_address == ttp_pkg::OFF_CONTROL) begin
            ctrl_reg <= avs_writedata[ttp_pkg::CTRL_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reload latches
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_latch_reg    <= ttp_pkg::RST_COUNT;
            t1_latch_reg     <= ttp_pkg::RST_COUNT;
            t2_pri_latch_reg <= ttp_pkg::RST_COUNT;
            t2_sec_latch_reg <= ttp_pkg::RST_COUNT;
            t3_latch_reg     <= ttp_pkg::RST_COUNT;
        end else if (wr_go) begin
            // latches follow every write; the timer two and three counter copies are gated below by their stop bits
            if (avs_address == ttp_pkg::OFF_PRESCALER_ONE) pre_latch_reg <= wdata;
            if (avs_address == ttp_pkg::OFF_TIMER_ONE) t1_latch_reg <= wdata;
            if (avs_address == ttp_pkg::OFF_T2_PRIMARY) t2_pri_latch_reg <= wdata;
            if (avs_address == ttp_pkg::OFF_T2_SECONDARY) t2_sec_latch_reg <= wdata;
            if (avs_address == ttp_pkg::OFF_TIMER_THREE) t3_latch_reg <= wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // counters
    assign pre_load = wr_go && avs_address == ttp_pkg::OFF_PRESCALER_ONE;
    assign t1_load  = wr_go && avs_address == ttp_pkg::OFF_TIMER_ONE;
    assign t2_load  = wr_go && avs_address == ttp_pkg::OFF_T2_PRIMARY && ctrl_reg.t2_stop;
    assign t3_load  = wr_go && avs_address == ttp_pkg::OFF_TIMER_THREE && ctrl_reg.t3_stop;
    // source bit set: every oscillator cycle for timer two, timer one underflow for timer three; else the divided tick
    assign t2_en    = (ctrl_reg.t2_src ? 1'b1 : osc_tick) && !ctrl_reg.t2_stop;
    assign t3_en    = (ctrl_reg.t3_src ? t1_uf : osc_tick) && !ctrl_reg.t3_stop;
    // the reload taken at an underflow is the latch of the following phase
    assign t2_reload = (phase_reg == ttp_pkg::PHASE_PRIMARY) ? t2_sec_latch_reg : t2_pri_latch_reg;

    ttp_osc_div u_osc_div (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .tick    (osc_tick)
    );

    ttp_reload_counter u_prescaler (
        .ref_clk      (ref_clk),
        .rst_n        (rst_n),
        .count_en     (osc_tick),
        .load_en      (pre_load),
        .load_value   (wdata),
        .reload_value (pre_latch_reg),
        .count_reg    (pre_count),
        .underflow    (pre_uf)
    );

    ttp_reload_counter u_timer_one (
        .ref_clk      (ref_clk),
        .rst_n        (rst_n),
        .count_en     (pre_uf && !ctrl_reg.t1_stop),
        .load_en      (t1_load),
        .load_value   (wdata),
        .reload_value (t1_latch_reg),
        .count_reg    (t1_count),
        .underflow    (t1_uf)
    );

    ttp_reload_counter u_timer_two (
        .ref_clk      (ref_clk),
        .rst_n        (rst_n),
        .count_en     (t2_en),
        .load_en      (t2_load),
        .load_value   (wdata),
        .reload_value (t2_reload),
        .count_reg    (t2_count),
        .underflow    (t2_uf)
    );

    ttp_reload_counter u_timer_three (
        .ref_clk      (ref_clk),
        .rst_n        (rst_n),
        .count_en     (t3_en),
        .load_en      (t3_load),
        .load_value   (wdata),
        .reload_value (t3_latch_reg),
        .count_reg    (t3_count),
        .underflow    (t3_uf)
    );

    // a primary write while stopped restarts the sequence in the primary phase
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg <= ttp_pkg::PHASE_PRIMARY;
        end else if (t2_load) begin
            phase_reg <= ttp_pkg::PHASE_PRIMARY;
        end else if (t2_uf) begin
            unique case (phase_reg)
                ttp_pkg::PHASE_PRIMARY:   phase_reg <= ttp_pkg::PHASE_SECONDARY;
                ttp_pkg::PHASE_SECONDARY: phase_reg <= ttp_pkg::PHASE_PRIMARY;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // request flags and underflow pulses
    always_comb begin
        irq_next = irq_reg;
        // software may only clear: a written zero clears, a one keeps
        if (wr_go && avs_address == ttp_pkg::OFF_IRQ_REQUEST) begin
            irq_next = irq_reg & avs_writedata[ttp_pkg::IRQ_W-1:0];
        end
        // set after clear so a same-cycle event is never lost
        irq_next.t1 = irq_next.t1 | t1_uf;
        irq_next.t2 = irq_next.t2 | t2_uf;
        irq_next.t3 = irq_next.t3 | t3_uf;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_reg <= ttp_pkg::RST_IRQ;
        end else begin
            irq_reg <= irq_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            t2_underflow_pulse <= 1'b0;
            t3_underflow_pulse <= 1'b0;
        end else begin
            t2_underflow_pulse <= t2_uf;
            t3_underflow_pulse <= t3_uf;
        end
    end

    assign irq_request = irq_reg;

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_osc_tick_spacing: assert property (osc_tick |=> !osc_tick[*8] ##1 !osc_tick[*7] ##1 osc_tick)
        else $error("oscillator tick spacing is not sixteen");
    a_pre_reload: assert property (pre_uf |=> pre_count == $past(pre_latch_reg) && t1_count != 8'h00
                                   || pre_count == $past(pre_latch_reg))
        else $error("prescaler did not reload from its latch");
    a_pre_decrement: assert property (osc_tick && !pre_load && pre_count != 8'h00
                                      |=> pre_count == $past(pre_count) - 8'h01)
        else $error("prescaler did not decrement");
    a_t1_irq_set: assert property (t1_uf |=> irq_request[ttp_pkg::IRQ_T1_BIT])
        else $error("timer one request flag not set");
    a_t3_irq_set: assert property (t3_uf |=> irq_request[ttp_pkg::IRQ_T3_BIT])
        else $error("timer three request flag not set");
    a_pre_write_load: assert property (pre_load |=> pre_count == $past(wdata) && pre_latch_reg == $past(wdata))
        else $error("prescaler write did not load both");
    a_t1_read_count: assert property (rd_capture && avs_address == ttp_pkg::OFF_TIMER_ONE
                                      |=> !avs_waitrequest && avs_readdata[7:0] == $past(t1_count))
        else $error("timer one read did not return count");
    a_t1_stop_hold: assert property (ctrl_reg.t1_stop && !t1_load |=> $stable(t1_count))
        else $error("timer one counted while stopped");
    a_t2_stopped_load: assert property (t2_load |=> t2_count == $past(wdata) && phase_reg == ttp_pkg::PHASE_PRIMARY)
        else $error("stopped primary write did not load counter");
    a_t2_running_write: assert property (wr_go && avs_address == ttp_pkg::OFF_T2_PRIMARY && !ctrl_reg.t2_stop && !t2_en
                                         |=> $stable(t2_count) && t2_pri_latch_reg == $past(wdata))
        else $error("running primary write reached the counter");
    a_t2_alternate: assert property (t2_uf && phase_reg == ttp_pkg::PHASE_PRIMARY
                                     |=> t2_count == $past(t2_sec_latch_reg) && phase_reg == ttp_pkg::PHASE_SECONDARY)
        else $error("timer two did not alternate to secondary");
    a_t3_stopped_load: assert property (t3_load |=> t3_count == $past(wdata) && t3_latch_reg == $past(wdata))
        else $error("stopped timer three write did not load counter");
    a_t2_pulse_single: assert property (t2_uf |=> t2_underflow_pulse ##1 (!t2_underflow_pulse || $past(t2_uf)))
        else $error("timer two pulse not single cycle");

    c_t2_full_cycle: cover property (t2_uf && phase_reg == ttp_pkg::PHASE_SECONDARY);
    c_t1_underflow: cover property (t1_uf);
    c_irq_clear_race: cover property (wr_go && avs_address == ttp_pkg::OFF_IRQ_REQUEST && t3_uf);
    c_t3_running_write: cover property (wr_go && avs_address == ttp_pkg::OFF_TIMER_THREE && !ctrl_reg.t3_stop);
endmodule : ttp_timers
`default_nettype wire

//--- sim/ttp_timers_test.sv
// self-checking bench for the triple timer block over its avalon-mm port
`timescale 1ns/1ps
`default_nettype none
module ttp_timers_test;
    localparam longint LIMIT = 20000;
    logic        ref_clk         = 1'b0;
    logic        rst_n           = 1'b0;
    logic [4:0]  avs_address     = 5'h00;
    logic        avs_read        = 1'b0;
    logic        avs_write       = 1'b0;
    logic [31:0] avs_writedata   = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [2:0]  irq_request;
    logic        t2_underflow_pulse;
    logic        t3_underflow_pulse;
    int          miscompares     = 0;
    int          samples_checked = 0;
    longint      cyc             = 0;
    logic [31:0] rd_a;
    logic [31:0] rd_b;
    longint      t0;
    longint      t1;
    longint      t2;

    ttp_timers ttp_timers_inst (
        .ref_clk            (ref_clk),
        .rst_n              (rst_n),
        .avs_address        (avs_address),
        .avs_read           (avs_read),
        .avs_write          (avs_write),
        .avs_writedata      (avs_writedata),
        .avs_readdata       (avs_readdata),
        .avs_waitrequest    (avs_waitrequest),
        .irq_request        (irq_request),
        .t2_underflow_pulse (t2_underflow_pulse),
        .t3_underflow_pulse (t3_underflow_pulse)
    );

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    // hang guard, well above the longest sequence
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            miscompares++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task results;
        if (miscompares == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    task check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // request held until the rising edge that samples waitrequest low; data taken there
    task bus(input logic wr, input logic [4:0] addr, input logic [31:0] data);
        @(posedge ref_clk);
        avs_address   <= addr;
        avs_writedata <= data;
        avs_read      <= ~wr;
        avs_write     <= wr;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge ref_clk);
        end
        rd_a = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task wr(input logic [4:0] addr, input logic [31:0] data);
        bus(1'b1, addr, data);
    endtask : wr

    task chk_rd(input logic [4:0] addr, input logic [31:0] exp);
        bus(1'b0, addr, 32'h0);
        check(rd_a, exp);
    endtask : chk_rd

    // returns the cycle of the next pulse; the pulse must stand one cycle only
    task wait_pulse(input bit which, output longint t);
        @(negedge ref_clk);
        while ((which ? t3_underflow_pulse : t2_underflow_pulse) !== 1'b1) begin
            @(negedge ref_clk);
        end
        t = cyc;
        @(negedge ref_clk);
        check(32'(which ? t3_underflow_pulse : t2_underflow_pulse), 32'h0);
    endtask : wait_pulse

    function automatic logic [31:0] ctl(input logic s1, input logic s2, input logic s3,
                                        input logic c2, input logic c3);
        ctl = 32'h0;
        ctl[ttp_pkg::CTRL_T1_STOP_BIT] = s1;
        ctl[ttp_pkg::CTRL_T2_STOP_BIT] = s2;
        ctl[ttp_pkg::CTRL_T3_STOP_BIT] = s3;
        ctl[ttp_pkg::CTRL_T2_SRC_BIT]  = c2;
        ctl[ttp_pkg::CTRL_T3_SRC_BIT]  = c3;
    endfunction : ctl

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        // prescaler read first, before the first divided tick lands
        chk_rd(ttp_pkg::OFF_PRESCALER_ONE, 32'(ttp_pkg::RST_COUNT));
        chk_rd(ttp_pkg::OFF_TIMER_ONE, 32'(ttp_pkg::RST_COUNT));
        chk_rd(ttp_pkg::OFF_T2_SECONDARY, 32'(ttp_pkg::RST_COUNT));
        chk_rd(ttp_pkg::OFF_CONTROL, 32'(ttp_pkg::RST_CONTROL));
        chk_rd(ttp_pkg::OFF_IRQ_REQUEST, 32'(ttp_pkg::RST_IRQ));
        chk_rd(5'h1c, 32'h0);
        wr(5'h1c, 32'hff);
        chk_rd(ttp_pkg::OFF_CONTROL, 32'h0);
        // timer two on the every-cycle source
        wr(ttp_pkg::OFF_CONTROL, ctl(0, 1, 0, 1, 0));
        wr(ttp_pkg::OFF_T2_PRIMARY, 32'h03);
        wr(ttp_pkg::OFF_T2_SECONDARY, 32'h05);
        chk_rd(ttp_pkg::OFF_T2_PRIMARY, 32'h03);
        chk_rd(ttp_pkg::OFF_T2_SECONDARY, 32'h05);
        wr(ttp_pkg::OFF_CONTROL, ctl(0, 0, 0, 1, 0));
        wait_pulse(0, t0);
        wait_pulse(0, t1);
        wait_pulse(0, t2);
        check(32'(t1 - t0), 32'd6);
        check(32'(t2 - t1), 32'd4);
        wr(ttp_pkg::OFF_T2_SECONDARY, 32'h01);
        chk_rd(ttp_pkg::OFF_T2_SECONDARY, 32'h01);
        wait_pulse(0, t0);
        wait_pulse(0, t1);
        wait_pulse(0, t2);
        check(32'(t2 - t0), 32'd6);
        bus(1'b0, ttp_pkg::OFF_IRQ_REQUEST, 32'h0);
        check(rd_a & 32'h2, 32'h2);
        // stopped timer two holds its count across a secondary write
        wr(ttp_pkg::OFF_CONTROL, ctl(0, 1, 0, 1, 0));
        bus(1'b0, ttp_pkg::OFF_T2_PRIMARY, 32'h0);
        rd_b = rd_a;
        repeat (20) @(posedge ref_clk);
        wr(ttp_pkg::OFF_T2_SECONDARY, 32'h07);
        chk_rd(ttp_pkg::OFF_T2_PRIMARY, rd_b);
        chk_rd(ttp_pkg::OFF_T2_SECONDARY, 32'h07);
        wr(ttp_pkg::OFF_T2_PRIMARY, 32'h02);
        chk_rd(ttp_pkg::OFF_T2_PRIMARY, 32'h02);
        // divided source: one primary plus one secondary period
        wr(ttp_pkg::OFF_CONTROL, ctl(0, 0, 0, 0, 0));
        wait_pulse(0, t0);
        wait_pulse(0, t1);
        wait_pulse(0, t2);
        check(32'(t2 - t0), 32'(ttp_pkg::OSC_DIV * 11));
        // running primary write lands mid-secondary: latch only, counter untouched
        wr(ttp_pkg::OFF_T2_PRIMARY, 32'h05);
        chk_rd(ttp_pkg::OFF_T2_PRIMARY, 32'h07);
        wait_pulse(0, t0);
        wait_pulse(0, t1);
        check(32'(t1 - t0), 32'(ttp_pkg::OSC_DIV * 6));
        // prescaler and timer one observed through timer three chained on them
        wr(ttp_pkg::OFF_CONTROL, ctl(1, 1, 1, 0, 0));
        wr(ttp_pkg::OFF_PRESCALER_ONE, 32'h01);
        wr(ttp_pkg::OFF_TIMER_ONE, 32'h5a);
        chk_rd(ttp_pkg::OFF_TIMER_ONE, 32'h5a);
        wr(ttp_pkg::OFF_TIMER_ONE, 32'h02);
        wr(ttp_pkg::OFF_TIMER_THREE, 32'h00);
        wr(ttp_pkg::OFF_CONTROL, ctl(0, 1, 0, 0, 1));
        wait_pulse(1, t0);
        wait_pulse(1, t1);
        check(32'(t1 - t0), 32'(ttp_pkg::OSC_DIV * 6));
        bus(1'b0, ttp_pkg::OFF_IRQ_REQUEST, 32'h0);
        check(rd_a & 32'h5, 32'h5);
        check(32'(irq_request) & 32'h5, 32'h5);
        wr(ttp_pkg::OFF_CONTROL, ctl(1, 1, 0, 0, 1));
        bus(1'b0, ttp_pkg::OFF_TIMER_ONE, 32'h0);
        rd_b = rd_a;
        repeat (200) @(posedge ref_clk);
        chk_rd(ttp_pkg::OFF_TIMER_ONE, rd_b);
        // timer three on the divided tick, latch-only write while running
        wr(ttp_pkg::OFF_CONTROL, ctl(1, 1, 1, 0, 0));
        wr(ttp_pkg::OFF_TIMER_THREE, 32'h04);
        chk_rd(ttp_pkg::OFF_TIMER_THREE, 32'h04);
        wr(ttp_pkg::OFF_CONTROL, ctl(1, 1, 0, 0, 0));
        wait_pulse(1, t0);
        wr(ttp_pkg::OFF_TIMER_THREE, 32'h01);
        wait_pulse(1, t1);
        wait_pulse(1, t2);
        check(32'(t1 - t0), 32'(ttp_pkg::OSC_DIV * 5));
        check(32'(t2 - t1), 32'(ttp_pkg::OSC_DIV * 2));
        wr(ttp_pkg::OFF_CONTROL, ctl(1, 1, 1, 0, 0));
        bus(1'b0, ttp_pkg::OFF_TIMER_THREE, 32'h0);
        rd_b = rd_a;
        repeat (100) @(posedge ref_clk);
        chk_rd(ttp_pkg::OFF_TIMER_THREE, rd_b);
        // all three timers stopped, so a cleared flag cannot come back
        wr(ttp_pkg::OFF_IRQ_REQUEST, 32'h0);
        chk_rd(ttp_pkg::OFF_IRQ_REQUEST, 32'h0);
        check(32'(irq_request), 32'h0);
        results();
    end
endmodule : ttp_timers_test
`default_nettype wire
